// ===== dsc_sync.sv
// Start-up and data-channel access logic of a disk synchronizer.
// Assumes the Wishbone master stands in for the host I/O instruction path and
// that channel lines are synchronous to clk_i.
`timescale 1ns/10ps
// Functional notes
// - Data-out instruction ignored while busy.
// - Initial clear pulse only when not busy and selected.
// - Initial clear releases clear hold and normalizes control state.
// - Set phase loads command word when not busy, not owner, selected.
// - Start prevented by any of five error or readiness conditions.
// - Load pulse starts 1 us one-shot; its end samples prevent condition.
// - No prevent: set busy and access request.
// - Prevent: set done, interrupt when enabled.
// - Not owner: relay request, direction downstream-to-channel and grant back.
// - Channel drops grant to end; owner then drops request.
// - Owner holds request until grant drops; it never drops it early.
// - Grant and request low, not owner: idle pulse sets inhibit.
// - 250 ns later clear seen flag, set owner; inhibit blocks request.
// - Another 250 ns clears inhibit; owner then drives request.
// - Outgoing request holds own seen flag set.
// - Owner does not relay grant downstream.
// - Grant fires begin-search, address strobe, two strobes with low nine bits.
// - Second strobe emits device pulse; read also clears channel pulse flag.
// - Request and grant low at least 400 ns before new request.
// - Second strobe always clears assembly register.
// - Begin-search clears access request only once ownership confirmed.
// - Owner drives own direction and request lines.
module dsc_sync
   import dsc_pkg::*;
(
   // Clock and reset.
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // Wishbone slave.
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // Status towards the host.
   output logic                        host_irq_o,
   // Channel side (upstream) and downstream device side.
   input  dsc_pkg::dsc_chan_s          chan_i,
   output dsc_pkg::dsc_chan_s          chan_o,
   input  dsc_pkg::dsc_chan_s          down_i,
   output dsc_pkg::dsc_chan_s          down_o,
   // Channel data strobes and bus.
   input  wire logic                   channel_pulse_i,
   input  wire logic                   ar_load_i,
   input  wire logic [AR_W-1:0]        ar_dat_i,
   output logic      [ADR_W-1:0]       chan_bus_o,
   output logic                        initial_address_strobe_o,
   output logic                        data_strobe_one_o,
   output logic                        data_strobe_two_o,
   output logic                        device_pulse_o,
   output logic                        begin_search_pulse_o
);
   import dsc_pkg::*;

   typedef struct packed {
      dsc_state_e     st;
      logic           busy;
      logic           done;
      logic           general_clear_hold;
      logic           access_req;
      logic           channel_owner_flag;
      logic           settle_inhibit_flag;
      logic           seen;
      logic           channel_pulse_received;
      logic           write_dir;
      logic           irq_en;
      logic [4:0]     cond;
      logic [AR_W-1:0] assembly_register;
      logic [3:0]     strobe_sh;
      logic           ack;
      logic [31:0]    rdat;
      logic [ADR_W-1:0] bus;
   } dsc_state_s;

   dsc_state_s q;
   dsc_state_s next_q;

   logic wb_req;
   logic wb_commit;
   logic host_data_out_instruction;
   logic device_select_decode;
   logic initial_clear_pulse;
   logic load_pulse_one;
   logic start_prevent_condition;
   logic chk_start;
   logic chk_done;
   logic step_start;
   logic step_done;
   logic idle_detect_pulse;
   logic grant_rise;
   logic grant_q;
   logic [7:0] tmr_load;

   // A write to the command word is the host's data-out instruction.
   // Writes land on the ack edge, while the master still holds address and data.
   assign wb_req = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wb_commit = wb_cyc_i & wb_stb_i & q.ack;
   assign device_select_decode = (wb_adr_i == REG_CMD);
   assign host_data_out_instruction = wb_commit & wb_we_i & device_select_decode & wb_sel_i[0];
   // Clear and set phases collapse into one cycle; the set phase also needs the owner flag clear.
   assign initial_clear_pulse = host_data_out_instruction & ~q.busy;
   assign load_pulse_one = initial_clear_pulse & ~q.channel_owner_flag;

   // Any one of the five conditions blocks the start; protection blocks only a write.
   assign start_prevent_condition = q.cond[CD_TSE] | q.cond[CD_DUP]
      | (q.write_dir & q.cond[CD_PROT]) | ~q.cond[CD_RDY] | q.cond[CD_PSF];

   // Channel idle seen while waiting for access.
   assign idle_detect_pulse = (q.st == ST_WAIT) & ~chan_i.grant & ~chan_i.req
      & ~q.channel_owner_flag;
   assign grant_rise = chan_i.grant & ~grant_q & q.channel_owner_flag;
   assign chk_start = load_pulse_one;
   assign step_start = idle_detect_pulse | (q.st == ST_STEP1 & step_done);
   assign tmr_load = 8'(STEP_CYC);

   dsc_timer #(.W(8)) u_check (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (chk_start),
      .load_i  (8'(CHECK_CYC)),
      .run_o   (),
      .done_o  (chk_done)
   );

   dsc_timer #(.W(8)) u_step (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (step_start),
      .load_i  (tmr_load),
      .run_o   (),
      .done_o  (step_done)
   );

   // Grant edge tracker; only its own previous value is kept here.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         grant_q <= 1'b0;
      else
         grant_q <= chan_i.grant;
   end

   // Next-state logic for the whole sequencer and register file.
   always_comb
   begin
      next_q = q;
      next_q.ack = wb_req;
      next_q.strobe_sh = {q.strobe_sh[2:0], 1'b0};
      // Register bus access.
      if (wb_req & ~wb_we_i)
      begin
         case (wb_adr_i)
            REG_CMD:  next_q.rdat = {22'h000000, q.write_dir, q.assembly_register[ADR_W-1:0]};
            REG_COND: next_q.rdat = {27'h0000000, q.cond};
            REG_STAT: next_q.rdat = {24'h000000, q.channel_pulse_received,
                                     q.general_clear_hold, q.seen,
                                     q.settle_inhibit_flag, q.access_req,
                                     q.channel_owner_flag, q.done, q.busy};
            REG_CTRL: next_q.rdat = {31'h00000000, q.irq_en};
            default:  next_q.rdat = 32'h00000000;
         endcase
      end
      if (wb_commit & wb_we_i & wb_sel_i[0])
      begin
         if (wb_adr_i == REG_COND)
            next_q.cond = wb_dat_i[4:0];
         if (wb_adr_i == REG_CTRL)
         begin
            next_q.irq_en = wb_dat_i[0];
            if (wb_dat_i[1])
               next_q.done = 1'b0;
         end
      end
      // Instruction start: normalize then load the command word.
      if (initial_clear_pulse)
      begin
         next_q.general_clear_hold = 1'b0;
         next_q.done = 1'b0;
         next_q.channel_pulse_received = 1'b0;
         next_q.assembly_register = '0;
         next_q.st = ST_CHECK;
      end
      if (load_pulse_one)
      begin
         next_q.assembly_register[ADR_W-1:0] = wb_dat_i[ADR_W-1:0];
         next_q.write_dir = wb_dat_i[CW_WRITE];
      end
      if (ar_load_i)
         next_q.assembly_register = ar_dat_i;
      if (channel_pulse_i)
         next_q.channel_pulse_received = 1'b1;
      // Seen flag tracks the outgoing request as long as it is raised.
      if (chan_o.req)
         next_q.seen = 1'b1;
      case (q.st)
         ST_IDLE:
         begin
         end
         ST_CHECK:
         begin
            if (chk_done)
            begin
               if (start_prevent_condition)
               begin
                  next_q.done = 1'b1;
                  next_q.general_clear_hold = 1'b1;
                  next_q.st = ST_IDLE;
               end
               else
               begin
                  next_q.busy = 1'b1;
                  next_q.access_req = 1'b1;
                  next_q.st = ST_WAIT;
               end
            end
         end
         ST_WAIT:
         begin
            if (idle_detect_pulse)
            begin
               next_q.settle_inhibit_flag = 1'b1;
               next_q.st = ST_STEP1;
            end
         end
         ST_STEP1:
         begin
            if (step_done)
            begin
               next_q.seen = 1'b0;
               next_q.channel_owner_flag = 1'b1;
               next_q.st = ST_STEP2;
            end
         end
         ST_STEP2:
         begin
            if (step_done)
            begin
               next_q.settle_inhibit_flag = 1'b0;
               next_q.st = ST_OWN;
            end
         end
         ST_OWN:
         begin
            // Grant confirms ownership and fires the start-up strobes.
            if (grant_rise)
            begin
               next_q.access_req = 1'b0;
               next_q.strobe_sh[0] = 1'b1;
            end
            if (q.strobe_sh[1])
               next_q.bus = q.assembly_register[ADR_W-1:0];
            if (q.strobe_sh[3])
            begin
               next_q.assembly_register = '0;
               if (~q.write_dir & ~channel_pulse_i) // A pulse in the same cycle wins.
                  next_q.channel_pulse_received = 1'b0;
            end
            // Grant dropped by the channel ends the transfer.
            if (grant_q & ~chan_i.grant)
            begin
               next_q.channel_owner_flag = 1'b0;
               next_q.busy = 1'b0;
               next_q.done = 1'b1;
               next_q.general_clear_hold = 1'b1;
               next_q.st = ST_IDLE;
            end
         end
         default:
            next_q.st = ST_IDLE;
      endcase
      // A done set by hardware beats a clear in the same cycle.
      if (q.done & ~next_q.done & ~(initial_clear_pulse)
          & ((q.st == ST_CHECK & chk_done & start_prevent_condition)))
         next_q.done = 1'b1;
   end

   // State register; the clear hold stands set after reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.st <= ST_IDLE;
         q.general_clear_hold <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Channel relay: pass-through until owner, then own lines.
   always_comb
   begin
      if (q.channel_owner_flag)
      begin
         chan_o.req = ~q.settle_inhibit_flag & q.busy;
         chan_o.wr = q.write_dir;
         chan_o.grant = 1'b0;
         down_o.grant = 1'b0;
      end
      else
      begin
         chan_o.req = down_i.req;
         chan_o.wr = down_i.wr;
         chan_o.grant = 1'b0;
         down_o.grant = chan_i.grant;
      end
      down_o.req = 1'b0;
      down_o.wr = 1'b0;
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign host_irq_o = q.done & q.irq_en;
   assign chan_bus_o = q.bus;
   assign begin_search_pulse_o = q.strobe_sh[0];
   assign initial_address_strobe_o = q.strobe_sh[1];
   assign data_strobe_one_o = q.strobe_sh[2];
   assign data_strobe_two_o = q.strobe_sh[3];
   assign device_pulse_o = q.strobe_sh[3];

   // Owner request never rises while inhibit is set.
   a_inhibit_blocks_req: assert property (@(posedge clk_i) disable iff (rst_i)
      q.settle_inhibit_flag |-> !(q.channel_owner_flag && chan_o.req))
      else $error("request raised during inhibit");
   a_busy_ignores_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      (host_data_out_instruction && q.busy) |=> $stable(q.write_dir))
      else $error("command taken while busy");
   a_clear_needs_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      initial_clear_pulse |-> (!q.busy && device_select_decode))
      else $error("clear pulse while busy");
   a_load_sets_check: assert property (@(posedge clk_i) disable iff (rst_i)
      load_pulse_one |=> (q.st == ST_CHECK && !q.general_clear_hold))
      else $error("load did not start check");
   a_check_time: assert property (@(posedge clk_i) disable iff (rst_i)
      load_pulse_one |-> ##[200:202] chk_done)
      else $error("one-shot length wrong");
   a_good_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && chk_done && !start_prevent_condition)
      |=> (q.busy && q.access_req))
      else $error("busy or request not set");
   a_bad_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && chk_done && start_prevent_condition) |=> q.done)
      else $error("done not set on prevent");
   a_owner_after_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      idle_detect_pulse |-> ##[50:52] q.channel_owner_flag)
      else $error("owner not set 250 ns after idle");
   a_no_grant_relay: assert property (@(posedge clk_i) disable iff (rst_i)
      q.channel_owner_flag |-> !down_o.grant)
      else $error("grant relayed while owner");
   a_search_chain: assert property (@(posedge clk_i) disable iff (rst_i)
      begin_search_pulse_o |-> ##1 initial_address_strobe_o ##2 device_pulse_o)
      else $error("start-up strobe chain broken");
endmodule : dsc_sync

// ===== dsc_pkg.sv
// Package for the disk synchronizer start-up and channel access block.
// Assumes a single 200 MHz clock and a classic Wishbone register port.
package dsc_pkg;
   // Clock period in picoseconds.
   localparam int CLK_PS = 5000;
   // One-shot and inhibit-sequence times, as printed, and their cycle counts.
   localparam int CHECK_NS = 1000;
   localparam int STEP_NS = 250;
   localparam int CHECK_CYC = (CHECK_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int STEP_CYC = (STEP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   // Register word offsets (byte addresses).
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_COND = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0C;
   // Status field positions.
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_OWNER = 2;
   localparam int ST_REQ = 3;
   localparam int ST_INH = 4;
   localparam int ST_SEEN = 5;
   localparam int ST_CLRH = 6;
   localparam int ST_CHNP = 7;
   // Condition register field positions.
   localparam int CD_TSE = 0;
   localparam int CD_DUP = 1;
   localparam int CD_PROT = 2;
   localparam int CD_RDY = 3;
   localparam int CD_PSF = 4;
   // Command word fields: bit 9 is write direction, bits 8..0 the address.
   localparam int CW_WRITE = 9;
   localparam int AR_W = 36;
   localparam int ADR_W = 9;

   // Channel signals grouped for the relay.
   typedef struct packed {
      logic req;
      logic grant;
      logic wr;
   } dsc_chan_s;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CHECK,
      ST_WAIT,
      ST_STEP1,
      ST_STEP2,
      ST_OWN
   } dsc_state_e;
endpackage : dsc_pkg

// ===== dsc_timer.sv
// Down-counting interval timer used for the one-shot and the settle steps.
// Assumes start is a one-cycle pulse; done pulses once when the count ends.
`timescale 1ns/10ps
module dsc_timer #(
   parameter int W = 8
) (
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Control.
   input  wire logic         start_i,
   input  wire logic [W-1:0] load_i,
   output logic              run_o,
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         run;
      logic         done;
   } dsc_tmr_s;

   dsc_tmr_s q;
   dsc_tmr_s next_q;

   // Count down while running; a new start restarts the interval.
   always_comb
   begin
      next_q = q;
      next_q.done = 1'b0;
      if (start_i)
      begin
         next_q.cnt = load_i;
         next_q.run = 1'b1;
      end
      else if (q.run)
      begin
         if (q.cnt <= W'(1))
         begin
            next_q.run = 1'b0;
            next_q.done = 1'b1;
         end
         else
         begin
            next_q.cnt = q.cnt - W'(1);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q <= '0;
      else
         q <= next_q;
   end

   assign run_o = q.run;
   assign done_o = q.done;
endmodule : dsc_timer

// ===== dsc_chan_model.sv
// Behavioural model of the shared data channel and of a busy device beyond it.
// Assumes lines synchronous to clk_i; the bench commands other traffic and ends.
`timescale 1ns/10ps
module dsc_chan_model
   import dsc_pkg::*;
(
   // Clock and reset.
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Bench commands.
   input  wire logic          other_i,
   input  wire logic          end_i,
   // Synchronizer side.
   input  dsc_pkg::dsc_chan_s dev_i,
   input  wire logic          device_pulse_i,
   output dsc_pkg::dsc_chan_s chan_o,
   output logic               channel_pulse_o,
   output logic               ar_load_o,
   output logic [AR_W-1:0]    ar_dat_o
);
   logic [1:0] wait_cnt;
   logic       granted;
   logic       ended;
   logic       load_due;

   // Another device on the channel shows as start and busy together.
   assign chan_o.req   = other_i;
   assign chan_o.grant = other_i | granted;
   assign chan_o.wr    = 1'b0;

   // Grant some cycles after a request; an end stays latched until the request drops,
   // so a slow device cannot be granted twice for one request.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !dev_i.req)
      begin
         wait_cnt <= 2'h0;
         granted  <= 1'b0;
         ended    <= 1'b0;
      end
      else if (end_i || ended)
      begin
         granted <= 1'b0;
         ended   <= 1'b1;
      end
      else if (wait_cnt == 2'h3)
         granted <= 1'b1;
      else
         wait_cnt <= wait_cnt + 2'h1;
   end

   // A write start is answered with the first word; the bus toggles when idle.
   always_ff @(posedge clk_i)
   begin
      load_due        <= !rst_i && device_pulse_i && dev_i.wr;
      ar_load_o       <= load_due;
      channel_pulse_o <= load_due;
      if (rst_i)
         ar_dat_o <= 36'h0;
      else if (load_due)
         ar_dat_o <= 36'h5_A5A5_A5A5;
      else
         ar_dat_o <= ~ar_dat_o;
   end
endmodule : dsc_chan_model

// ===== tb_top.sv
// Self-checking bench for the synchronizer start-up and channel access block.
// Assumes the package, the design and the channel model are compiled first.
`timescale 1ns/10ps
module tb_top;
   import dsc_pkg::*;
   localparam int LIMIT = 20000;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] rdat;
   logic        wb_ack;
   logic        irq;
   logic        other = 1'b1;
   logic        end_pl = 1'b0;
   dsc_chan_s   chan_in;
   dsc_chan_s   chan_out;
   dsc_chan_s   down_in = 3'b000;
   dsc_chan_s   down_out;
   logic        cpulse;
   logic        arload;
   logic [35:0] ardat;
   logic [8:0]  bus;
   logic        ias;
   logic        ds1;
   logic        ds2;
   logic        devp;
   logic        bsp;
   int          err_total = 0;
   int          checks = 0;
   int          cyc_cnt = 0;

   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 clk = ~clk;

   dsc_sync i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(rdat), .wb_ack_o(wb_ack), .host_irq_o(irq), .chan_i(chan_in),
      .chan_o(chan_out), .down_i(down_in), .down_o(down_out), .channel_pulse_i(cpulse),
      .ar_load_i(arload), .ar_dat_i(ardat), .chan_bus_o(bus),
      .initial_address_strobe_o(ias), .data_strobe_one_o(ds1), .data_strobe_two_o(ds2),
      .device_pulse_o(devp), .begin_search_pulse_o(bsp));

   dsc_chan_model i_chan (.clk_i(clk), .rst_i(rst), .other_i(other), .end_i(end_pl),
      .dev_i(chan_out), .device_pulse_i(devp), .chan_o(chan_in),
      .channel_pulse_o(cpulse), .ar_load_o(arload), .ar_dat_o(ardat));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   // A hang counts as a mismatch and goes straight to the verdict.
   always @(posedge clk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIMIT)
      begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // Classic Wishbone cycle; the request holds until ack is sampled high.
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_dat <= wd;
      @(posedge clk);
      while (wb_ack !== 1'b1)
         @(posedge clk);
      rd = rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge clk);
   endtask : wb_xfer

   task automatic wb_wr(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] dummy;
      wb_xfer(1'b1, adr, wd, dummy);
   endtask : wb_wr

   // Watched outputs: 0 outgoing request, 1 begin-search, 2 device pulse.
   function automatic logic watched(input int which);
      case (which)
         0: return chan_out.req;
         1: return bsp;
         default: return devp;
      endcase
   endfunction : watched

   // A wait that runs out counts as a mismatch.
   task automatic wait_hi(input int which, input int bound);
      int n;
      n = 0;
      while (watched(which) !== 1'b1 && n < bound)
      begin
         @(posedge clk);
         n++;
      end
      if (watched(which) !== 1'b1)
      begin
         err_total++;
         $display("MISMATCH at %0t: wait %0d ran out", $time, which);
      end
   endtask : wait_hi

   // Strobe order after begin-search: {address, strobe one, strobe two, device pulse}.
   logic [3:0]  seq [3] = '{4'b1000, 4'b0100, 4'b0011};
   logic [31:0] d;
   logic [4:0]  cond;
   int          t0;

   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb_xfer(1'b0, REG_STAT, 32'h0, d);
      chk(d, 32'h40, "status after reset");
      wb_xfer(1'b0, 8'h10, 32'h0, d);
      chk(d, 32'h0, "unmapped read");
      wb_wr(REG_CTRL, 32'h1);
      // Each start-prevent cause alone, with write direction so protection counts.
      for (int i = 0; i < 5; i++)
      begin
         cond = 5'h08 ^ 5'(5'h01 << i);
         wb_wr(REG_COND, {27'h0, cond});
         wb_wr(REG_CMD, 32'h200 + 32'(i));
         repeat (CHECK_CYC - 20) @(posedge clk);
         wb_xfer(1'b0, REG_STAT, 32'h0, d);
         chk(d[1:0], 2'b00, "done before one-shot end");
         repeat (30) @(posedge clk);
         wb_xfer(1'b0, REG_STAT, 32'h0, d);
         chk({d[6], d[1:0]}, 3'b110, "prevented start");
         chk(irq, 1'b1, "interrupt on prevent");
         wb_wr(REG_CTRL, 32'h3);
         chk(irq, 1'b0, "interrupt after clear");
      end
      $display("test prevent done");
      // Read start while another device owns the channel.
      down_in <= 3'b101;
      wb_wr(REG_COND, 32'h08);
      wb_wr(REG_CMD, 32'h0A5);
      repeat (CHECK_CYC + 10) @(posedge clk);
      wb_xfer(1'b0, REG_STAT, 32'h0, d);
      chk(d[3:0], 4'b1001, "busy and request set");
      chk(chan_out.req, 1'b1, "relayed request");
      chk(chan_out.wr, 1'b1, "relayed direction");
      chk(down_out.grant, 1'b1, "relayed grant");
      wb_wr(REG_CMD, 32'h1FF);
      wb_xfer(1'b0, REG_CMD, 32'h0, d);
      chk(d[9:0], 10'h0A5, "command kept while busy");
      other   <= 1'b0;
      down_in <= 3'b000;
      t0 = cyc_cnt;
      repeat (70) @(posedge clk);
      wb_xfer(1'b0, REG_STAT, 32'h0, d);
      chk(d[5:0], 6'b011101, "owner under inhibit");
      chk(chan_out.req, 1'b0, "request held off");
      wait_hi(0, 300);
      chk(36'(cyc_cnt - t0 >= 2 * STEP_CYC && cyc_cnt - t0 <= 2 * STEP_CYC + 12), 36'h1,
          "request delay");
      wait_hi(1, 20);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         chk({ias, ds1, ds2, devp}, seq[i], "start strobes");
         if (i == 2)
            chk(bus, 9'h0A5, "initial address on bus");
      end
      chk(down_out.grant, 1'b0, "grant not relayed");
      chk(chan_out.wr, 1'b0, "own read direction");
      wb_xfer(1'b0, REG_STAT, 32'h0, d);
      chk({d[7], d[5], d[3], d[2]}, 4'b0101, "owner status");
      end_pl <= 1'b1;
      @(posedge clk);
      end_pl <= 1'b0;
      repeat (5) @(posedge clk);
      chk(chan_out.req, 1'b0, "request dropped");
      wb_xfer(1'b0, REG_STAT, 32'h0, d);
      chk(d[2:0], 3'b010, "normal end");
      $display("test read start done");
      // Write start on an idle channel.
      wb_wr(REG_CTRL, 32'h3);
      wb_wr(REG_CMD, 32'h333);
      wait_hi(0, CHECK_CYC + 200);
      chk(chan_out.wr, 1'b1, "own write direction");
      wait_hi(2, 30);
      chk(bus, 9'h133, "write start address");
      repeat (5) @(posedge clk);
      wb_xfer(1'b0, REG_STAT, 32'h0, d);
      chk(d[7], 1'b1, "first word pulse seen");
      $display("test write start done");
      report_and_stop();
   end
endmodule : tb_top
